// ==== pkg/atc_pkg.sv ====
package atc_pkg;
   // Register byte offsets
   localparam logic [7:0] ATC_OFS_CTRL3 = 8'h00;
   localparam logic [7:0] ATC_OFS_MODE = 8'h04;
   localparam logic [7:0] ATC_OFS_TSRC = 8'h08;
   localparam logic [7:0] ATC_OFS_SCAN = 8'h0C;
   localparam logic [7:0] ATC_OFS_ISTAT = 8'h10;
   localparam logic [7:0] ATC_OFS_IMASK = 8'h14;
   // Control register three fields
   localparam int ATC_POS_DIGEN = 16;
   localparam int ATC_POS_VREF = 13;
   localparam int ATC_POS_TSUSP = 12;
   localparam int ATC_POS_UPDATE_READY_IRQ_ENABLE = 11;
   localparam int ATC_POS_UPDATE_READY_FLAG = 10;
   localparam int ATC_POS_SOFTWARE_SAMPLE_HOLD = 9;
   localparam int ATC_POS_RQ = 8;
   localparam int ATC_POS_GLSW = 7;
   localparam int ATC_POS_GSW = 6;
   localparam int ATC_POS_INSEL = 0;
   // Dedicated trigger mode fields
   localparam int ATC_POS_ALT = 16;
   localparam int ATC_POS_STRGEN = 8;
   localparam int ATC_POS_SSAMP = 0;
   localparam int ATC_NDED = 5;
   localparam int ATC_NDIG = 3;
   localparam int ATC_NIN = 4;
   localparam int ATC_NCONV = 8;
   localparam int ATC_FLD_STEP = 8;
   localparam int ATC_POS_SCANSRC = 16;
   localparam int ATC_POS_SCANSEL = 0;
   // Writable bit masks
   localparam logic [31:0] ATC_MODE_MASK = 32'h03FF1F1F;
   localparam logic [31:0] ATC_TSRC_MASK = 32'h1F1F1F1F;
   localparam logic [31:0] ATC_SCAN_MASK = 32'h001F000F;
   localparam logic [31:0] ATC_ZERO = 32'h00000000;
   // Trigger source codes
   localparam logic [4:0] ATC_TRG_NONE = 5'h00;
   localparam logic [4:0] ATC_TRG_GSW = 5'h01;
   localparam logic [4:0] ATC_TRG_GLSW = 5'h02;
   localparam logic [4:0] ATC_TRG_SCAN = 5'h03;
   localparam logic [4:0] ATC_TRG_INT0 = 5'h04;
   localparam logic [4:0] ATC_TRG_TMR1 = 5'h05;
   localparam logic [4:0] ATC_TRG_TMR3 = 5'h06;
   localparam logic [4:0] ATC_TRG_TMR5 = 5'h07;
   localparam logic [4:0] ATC_TRG_OC1 = 5'h08;
   localparam logic [4:0] ATC_TRG_OC3 = 5'h09;
   localparam logic [4:0] ATC_TRG_OC5 = 5'h0A;
   localparam logic [4:0] ATC_TRG_CMP1 = 5'h0B;
   localparam logic [4:0] ATC_TRG_CMP2 = 5'h0C;
   // Reference and alternate input codes
   localparam logic [2:0] ATC_REF_INT = 3'h0;
   localparam logic [2:0] ATC_REF_EXTH = 3'h1;
   localparam logic [2:0] ATC_REF_EXTL = 3'h2;
   localparam logic [2:0] ATC_REF_EXT = 3'h3;
   localparam logic [1:0] ATC_ALT_DEF = 2'h0;
   localparam logic [1:0] ATC_ALT_ALT = 2'h1;
   // Interrupt status bits
   localparam int ATC_NEV = 2;
   localparam int ATC_EV_UPD = 0;
   localparam int ATC_EV_REQ = 1;

   typedef struct packed {
      logic int0;
      logic [2:0] tmr;
      logic [2:0] ocmp;
      logic [1:0] cmp;
   } atc_trig_src_t;

   typedef struct packed {
      logic high_ext;
      logic low_ext;
   } atc_ref_t;
endpackage

// ==== core/atc_core.sv ====
// Operation
// R1: Converters 0 to 2 each run digital logic only while enable bit is one.
// R2: Reference code 000 to 011 picks supply or external rails; 1xx reserved.
// R3: Trigger suspend blocks every new conversion start, module stays on.
// R4: Update-ready is set only when suspended and no conversion runs.
// R5: Update-ready interrupt enable raises interrupt when update-ready gets set; irq here also needs imask bit 0 set.
// R6: Software sample bit holds sampling with top priority, ignoring sample time.
// R7: Software sample acts only on class 2 and 3 inputs of shared converter.
// R8: Software clears sample bit itself, then sets the conversion request.
// R9: Request bit converts selected input and self-clears the next cycle.
// R10: Software should zero all trigger source fields when using software bits.
// R11: Level software trigger converts all inputs selecting it while set.
// R12: Dedicated converters 0 to 4 choose default or alternate input, rest reserved.
// R13: Dedicated converters 0 to 4 choose presynchronized triggers per bit.
// R14: Five-bit trigger source decode: none, software, scan, pins, timers, compares.
// R15: Scan trigger code also needs scan source and scan select programmed.
// R16: Trigger source register holds four five-bit fields, other bits zero.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module atc_core
   import atc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire atc_trig_src_t trig_src,
   input wire logic [ATC_NCONV-1:0] conv_busy,
   output logic [ATC_NDIG-1:0] digital_enable,
   output atc_ref_t ref_select,
   output logic shared_sample_hold,
   output logic [ATC_NIN-1:0] conv_start,
   output logic request_start,
   output logic [5:0] request_input,
   output logic [ATC_NDED-1:0] alternate_input,
   output logic [ATC_NDED-1:0] presync_trigger_enable,
   output logic [ATC_NDED-1:0] sync_sampling_enable,
   output logic irq
);

   // Decode one trigger source code against live sources
   function automatic logic trig_hit(input logic [4:0] code,
                                     input atc_trig_src_t s,
                                     input logic lvl, input logic edg);
      logic hit;
      hit = 1'b0;
      case (code)
         ATC_TRG_GSW: hit = edg;
         ATC_TRG_GLSW: hit = lvl;
         ATC_TRG_INT0: hit = s.int0;
         ATC_TRG_TMR1: hit = s.tmr[0];
         ATC_TRG_TMR3: hit = s.tmr[1];
         ATC_TRG_TMR5: hit = s.tmr[2];
         ATC_TRG_OC1: hit = s.ocmp[0];
         ATC_TRG_OC3: hit = s.ocmp[1];
         ATC_TRG_OC5: hit = s.ocmp[2];
         ATC_TRG_CMP1: hit = s.cmp[0];
         ATC_TRG_CMP2: hit = s.cmp[1];
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Register state
   logic [ATC_NDIG-1:0] dig_en, next_dig_en;
   logic [2:0] vref, next_vref;
   logic tsusp, next_tsusp;
   logic update_ready_irq_enable, next_update_ready_irq_enable;
   logic software_sample_hold, next_software_sample_hold;
   logic glsw, next_glsw;
   logic [5:0] insel, next_insel;
   logic req_pend, next_req_pend;
   logic edge_pend, next_edge_pend;
   logic upd_rdy, next_upd_rdy;
   logic [31:0] mode, next_mode;
   logic [31:0] tsrc, next_tsrc;
   logic [31:0] scan, next_scan;
   logic [ATC_NEV-1:0] istat, next_istat;
   logic [ATC_NEV-1:0] imask, next_imask;
   logic [31:0] next_rdata;
   logic next_wait;
   logic wr_go, rd_go;
   logic [ATC_NEV-1:0] events;

   // Bus handshake qualifiers
   assign wr_go = avs_write & ~avs_waitrequest;
   assign rd_go = avs_read & ~avs_waitrequest;

   // Register file, handshake and sticky status
   always_comb begin
      next_dig_en = dig_en;
      next_vref = vref;
      next_tsusp = tsusp;
      next_update_ready_irq_enable = update_ready_irq_enable;
      next_software_sample_hold = software_sample_hold;
      next_glsw = glsw;
      next_insel = insel;
      next_mode = mode;
      next_tsrc = tsrc;
      next_scan = scan;
      next_imask = imask;
      next_istat = istat;
      next_rdata = avs_readdata;
      // R9: request lasts one cycle
      next_req_pend = 1'b0;
      next_edge_pend = 1'b0;
      next_wait = ~((avs_read | avs_write) & avs_waitrequest);
      // R4: ready only when suspended and idle
      next_upd_rdy = tsusp & ~(|conv_busy);
      events = '0;
      // R5: interrupt on hardware set
      events[ATC_EV_UPD] = next_upd_rdy & ~upd_rdy & update_ready_irq_enable;
      events[ATC_EV_REQ] = req_pend & ~tsusp;
      if (avs_read & avs_waitrequest) begin
         next_rdata = ATC_ZERO;
         unique case (avs_address)
            ATC_OFS_CTRL3: begin
               next_rdata[ATC_POS_DIGEN+:ATC_NDIG] = dig_en;
               next_rdata[ATC_POS_VREF+:3] = vref;
               next_rdata[ATC_POS_TSUSP] = tsusp;
               next_rdata[ATC_POS_UPDATE_READY_IRQ_ENABLE] = update_ready_irq_enable;
               next_rdata[ATC_POS_UPDATE_READY_FLAG] = upd_rdy;
               next_rdata[ATC_POS_SOFTWARE_SAMPLE_HOLD] = software_sample_hold;
               next_rdata[ATC_POS_RQ] = req_pend;
               next_rdata[ATC_POS_GLSW] = glsw;
               next_rdata[ATC_POS_INSEL+:6] = insel;
            end
            ATC_OFS_MODE: next_rdata = mode;
            // R16: unused bits read zero
            ATC_OFS_TSRC: next_rdata = tsrc;
            ATC_OFS_SCAN: next_rdata = scan;
            ATC_OFS_ISTAT: next_rdata[ATC_NEV-1:0] = istat;
            ATC_OFS_IMASK: next_rdata[ATC_NEV-1:0] = imask;
            default: next_rdata = ATC_ZERO;
         endcase
      end
      if (wr_go) begin
         unique case (avs_address)
            ATC_OFS_CTRL3: begin
               next_dig_en = avs_writedata[ATC_POS_DIGEN+:ATC_NDIG];
               next_vref = avs_writedata[ATC_POS_VREF+:3];
               next_tsusp = avs_writedata[ATC_POS_TSUSP];
               next_update_ready_irq_enable = avs_writedata[ATC_POS_UPDATE_READY_IRQ_ENABLE];
               next_software_sample_hold = avs_writedata[ATC_POS_SOFTWARE_SAMPLE_HOLD];
               // R9: writing one requests a conversion
               next_req_pend = avs_writedata[ATC_POS_RQ];
               next_glsw = avs_writedata[ATC_POS_GLSW];
               next_edge_pend = avs_writedata[ATC_POS_GSW];
               next_insel = avs_writedata[ATC_POS_INSEL+:6];
            end
            ATC_OFS_MODE: next_mode = avs_writedata & ATC_MODE_MASK;
            // R16: four five-bit fields kept
            ATC_OFS_TSRC: next_tsrc = avs_writedata & ATC_TSRC_MASK;
            ATC_OFS_SCAN: next_scan = avs_writedata & ATC_SCAN_MASK;
            ATC_OFS_IMASK: next_imask = avs_writedata[ATC_NEV-1:0];
            default: next_imask = imask;
         endcase
      end
      // Read clears what was shown, new events win
      if (rd_go && avs_address == ATC_OFS_ISTAT) begin
         next_istat = istat & ~avs_readdata[ATC_NEV-1:0];
      end
      next_istat = next_istat | events;
   end

   // Register file flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dig_en <= '0;
         vref <= ATC_REF_INT;
         tsusp <= 1'b0;
         update_ready_irq_enable <= 1'b0;
         software_sample_hold <= 1'b0;
         glsw <= 1'b0;
         insel <= '0;
         req_pend <= 1'b0;
         edge_pend <= 1'b0;
         upd_rdy <= 1'b0;
         mode <= ATC_ZERO;
         tsrc <= ATC_ZERO;
         scan <= ATC_ZERO;
         istat <= '0;
         imask <= '0;
         avs_readdata <= ATC_ZERO;
         avs_waitrequest <= 1'b1;
      end else begin
         dig_en <= next_dig_en;
         vref <= next_vref;
         tsusp <= next_tsusp;
         update_ready_irq_enable <= next_update_ready_irq_enable;
         software_sample_hold <= next_software_sample_hold;
         glsw <= next_glsw;
         insel <= next_insel;
         req_pend <= next_req_pend;
         edge_pend <= next_edge_pend;
         upd_rdy <= next_upd_rdy;
         mode <= next_mode;
         tsrc <= next_tsrc;
         scan <= next_scan;
         istat <= next_istat;
         imask <= next_imask;
         avs_readdata <= next_rdata;
         avs_waitrequest <= next_wait;
      end
   end

   // Output next values
   logic [ATC_NDIG-1:0] next_digital_enable;
   atc_ref_t next_ref_select;
   logic next_shared_sample_hold;
   logic [ATC_NIN-1:0] next_conv_start;
   logic next_request_start;
   logic [5:0] next_request_input;
   logic [ATC_NDED-1:0] next_alternate_input;
   logic [ATC_NDED-1:0] next_presync;
   logic [ATC_NDED-1:0] next_syncsamp;
   logic next_irq;

   // Trigger routing and converter controls
   always_comb begin
      logic [4:0] code;
      logic [4:0] scan_src;
      logic hit;
      logic [ATC_NIN-1:0] en_all;
      code = '0;
      hit = 1'b0;
      // Inputs without a digital enable bit always run
      en_all = '1;
      en_all[ATC_NDIG-1:0] = dig_en;
      scan_src = scan[ATC_POS_SCANSRC+:5];
      // R1: per-converter digital enables
      next_digital_enable = dig_en;
      // R2: reference decode, reserved falls back to supply
      next_ref_select = '0;
      unique case (vref)
         ATC_REF_EXTH: next_ref_select.high_ext = 1'b1;
         ATC_REF_EXTL: next_ref_select.low_ext = 1'b1;
         ATC_REF_EXT: next_ref_select = '1;
         default: next_ref_select = '0;
      endcase
      // R6: forced sampling of shared converter
      // R7: class 1 inputs never see it
      next_shared_sample_hold = software_sample_hold;
      for (int i = 0; i < ATC_NIN; i++) begin
         // R14: per-input source decode
         code = tsrc[i*ATC_FLD_STEP+:5];
         // R11: level trigger via own or scan field
         hit = trig_hit(code, trig_src, glsw, edge_pend);
         if (code == ATC_TRG_SCAN) begin
            hit = scan[ATC_POS_SCANSEL+i] &
                  trig_hit(scan_src, trig_src, glsw, edge_pend);
         end
         // R1: disabled converter does not start
         hit = hit & en_all[i];
         // R3: suspend blocks all starts
         next_conv_start[i] = hit & ~tsusp;
      end
      // R9: individual request with selected input
      next_request_start = req_pend & ~tsusp;
      next_request_input = insel;
      for (int j = 0; j < ATC_NDED; j++) begin
         // R12: only code 01 picks the alternate input
         next_alternate_input[j] =
            (mode[ATC_POS_ALT+2*j+:2] == ATC_ALT_ALT);
         // R13: presynchronized trigger choice
         next_presync[j] = mode[ATC_POS_STRGEN+j];
         next_syncsamp[j] = mode[ATC_POS_SSAMP+j];
      end
      next_irq = |(next_istat & imask);
   end

   // Output flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         digital_enable <= '0;
         ref_select <= '0;
         shared_sample_hold <= 1'b0;
         conv_start <= '0;
         request_start <= 1'b0;
         request_input <= '0;
         alternate_input <= '0;
         presync_trigger_enable <= '0;
         sync_sampling_enable <= '0;
         irq <= 1'b0;
      end else begin
         digital_enable <= next_digital_enable;
         ref_select <= next_ref_select;
         shared_sample_hold <= next_shared_sample_hold;
         conv_start <= next_conv_start;
         request_start <= next_request_start;
         request_input <= next_request_input;
         alternate_input <= next_alternate_input;
         presync_trigger_enable <= next_presync;
         sync_sampling_enable <= next_syncsamp;
         irq <= next_irq;
      end
   end

endmodule
`default_nettype wire

// ==== testbench/atc_core_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module atc_core_sva
   import atc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire atc_trig_src_t trig_src,
   input wire logic [ATC_NDIG-1:0] digital_enable,
   input wire atc_ref_t ref_select,
   input wire logic [ATC_NIN-1:0] conv_start,
   input wire logic request_start,
   input wire logic [5:0] request_input,
   input wire logic [ATC_NDED-1:0] alternate_input
);
   logic [31:0] ctrl_q, mode_q, tsrc_q;
   logic [ATC_NDED-1:0] alt_exp;
   logic [2:0] v;
   logic [1:0] ref_exp;
   // Shadow of registers as written over the bus
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q <= ATC_ZERO;
         mode_q <= ATC_ZERO;
         tsrc_q <= ATC_ZERO;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == ATC_OFS_CTRL3) ctrl_q <= avs_writedata;
         if (avs_address == ATC_OFS_MODE) mode_q <= avs_writedata;
         if (avs_address == ATC_OFS_TSRC) tsrc_q <= avs_writedata;
      end
   end
   // Expected decodes of the shadow
   assign v = ctrl_q[15:13];
   assign ref_exp = {v == ATC_REF_EXTH || v == ATC_REF_EXT,
      v == ATC_REF_EXTL || v == ATC_REF_EXT};
   always_comb begin
      for (int i = 0; i < ATC_NDED; i++) begin
         alt_exp[i] = mode_q[ATC_POS_ALT + 2 * i +: 2] == ATC_ALT_ALT;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_ctrl;
      avs_write && !avs_waitrequest && avs_address == ATC_OFS_CTRL3;
   endsequence
   sequence s_mode;
      avs_write && !avs_waitrequest && avs_address == ATC_OFS_MODE;
   endsequence
   property p_digen;
      s_ctrl |-> ##[1:2] digital_enable == ctrl_q[18:16];
   endproperty
   a_digen: assert property (p_digen) else $error("enable copy wrong");
   property p_ref;
      s_ctrl |-> ##[1:2] ref_select == ref_exp;
   endproperty
   a_ref: assert property (p_ref) else $error("reference decode wrong");
   property p_alt;
      s_mode |-> ##[1:2] alternate_input == alt_exp;
   endproperty
   a_alt: assert property (p_alt) else $error("alternate input wrong");
   property p_req;
      s_ctrl ##0 (avs_writedata[8] && !avs_writedata[12])
         |-> ##2 request_start && request_input == ctrl_q[5:0];
   endproperty
   a_req: assert property (p_req) else $error("request not issued");
   property p_pulse;
      request_start |=> !request_start;
   endproperty
   a_pulse: assert property (p_pulse) else $error("request too long");
   property p_susp;
      ctrl_q[12] && $past(ctrl_q[12]) |-> conv_start == '0 && !request_start;
   endproperty
   a_susp: assert property (p_susp) else $error("start while held");
   property p_level;
      (ctrl_q[7] && !ctrl_q[12] && tsrc_q[28:24] == ATC_TRG_GLSW) [*3]
         |-> conv_start[3];
   endproperty
   a_level: assert property (p_level) else $error("level start lost");
   property p_int0;
      (!ctrl_q[12] && tsrc_q[28:24] == ATC_TRG_INT0) [*3]
         |-> conv_start[3] == $past(trig_src.int0);
   endproperty
   a_int0: assert property (p_int0) else $error("pin start wrong");
endmodule
bind atc_core atc_core_sva i_sva (.clk(clk), .resetn(resetn),
   .avs_address(avs_address), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .trig_src(trig_src), .digital_enable(digital_enable),
   .ref_select(ref_select), .conv_start(conv_start),
   .request_start(request_start), .request_input(request_input),
   .alternate_input(alternate_input));
`default_nettype wire

// ==== testbench/atc_conv_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module atc_conv_model
   import atc_pkg::*;
(
   input wire logic clk,
   input wire logic slow,
   input wire atc_trig_src_t src_cmd,
   input wire logic [ATC_NIN-1:0] conv_start,
   output atc_trig_src_t trig_src,
   output logic [ATC_NCONV-1:0] conv_busy
);
   int cnt [ATC_NIN];
   // Sources follow command; a start keeps its converter busy
   always @(posedge clk) begin
      trig_src <= src_cmd;
      conv_busy[ATC_NCONV-1:ATC_NIN] <= '0;
      for (int i = 0; i < ATC_NIN; i++) begin
         if (conv_start[i]) cnt[i] = slow ? 12 : 2;
         else if (cnt[i] > 0) cnt[i] = cnt[i] - 1;
         conv_busy[i] <= cnt[i] > 0;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb_adc_trigger_sample_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_adc_trigger_sample_control
   import atc_pkg::*;
;
   logic clk, resetn, rd, wr, waitreq, slow, software_sample_hold, irq, rqs;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, q, d;
   logic [5:0] rqi;
   logic [ATC_NIN-1:0] cs;
   logic [ATC_NDIG-1:0] den;
   logic [ATC_NDED-1:0] alt, psy, ssm;
   logic [ATC_NCONV-1:0] busy;
   atc_trig_src_t src_cmd, tsrc;
   atc_ref_t rsel;
   int bad_count, checks_done, cycles, k, n, c;
   logic [5:0] exp_q [$];
   atc_core i_dut (.clk(clk), .resetn(resetn), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_readdata(rdata), .avs_waitrequest(waitreq), .trig_src(tsrc),
      .conv_busy(busy), .digital_enable(den), .ref_select(rsel),
      .shared_sample_hold(software_sample_hold), .conv_start(cs), .request_start(rqs),
      .request_input(rqi), .alternate_input(alt),
      .presync_trigger_enable(psy), .sync_sampling_enable(ssm), .irq(irq));
   atc_conv_model i_model (.clk(clk), .slow(slow), .src_cmd(src_cmd),
      .conv_start(cs), .trig_src(tsrc), .conv_busy(busy));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One bus access; request held until waitrequest low
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] dat);
      int t;
      t = 0;
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= dat;
      do begin
         @(posedge clk);
         t++;
      end while (waitreq !== 1'b0 && t < 40);
      if (t >= 40) bad_count++;
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(q, exp);
   endtask
   function automatic logic [31:0] ref_exp(input int v);
      return (v == 1) ? 2'h2 : (v == 2) ? 2'h1 : (v == 3) ? 2'h3 : 2'h0;
   endfunction
   initial begin
      resetn = 1'b0;
      {rd, wr, addr, wdata, slow, src_cmd} = '0;
      void'($urandom(32'hEBBB));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped place at 0x18
      for (k = 0; k < 7; k++) rchk(8'(k * 4), 32'h00000000);
      bus(1'b1, 8'h18, 32'hFFFFFFFF);
      rchk(8'h18, 32'h00000000);
      $display("test reset done");
      repeat (4) begin
         d = $urandom;
         bus(1'b1, ATC_OFS_MODE, d);
         rchk(ATC_OFS_MODE, d & ATC_MODE_MASK);
         @(negedge clk);
         for (k = 0; k < ATC_NDED; k++) chk(alt[k], d[16 + 2 * k +: 2] == 1);
         chk(psy, d[12:8]);
         chk(ssm, d[4:0]);
         @(posedge clk);
         d = $urandom;
         bus(1'b1, ATC_OFS_TSRC, d);
         rchk(ATC_OFS_TSRC, d & ATC_TSRC_MASK);
      end
      $display("test fields done");
      bus(1'b1, ATC_OFS_TSRC, {27'h0, ATC_TRG_GLSW});
      for (k = 0; k < 8; k++) begin
         d = {13'h0, 3'($urandom), 3'(k), 13'h0080};
         bus(1'b1, ATC_OFS_CTRL3, d);
         @(negedge clk);
         chk(den, d[18:16]);
         chk({30'h0, rsel}, ref_exp(k));
         chk(cs[0], d[16]);
         @(posedge clk);
      end
      $display("test enables done");
      // Every source code on input 3, sources low then high
      for (c = 0; c < 32; c++) begin
         bus(1'b1, ATC_OFS_TSRC, {3'h0, 5'(c), 24'h0});
         for (n = 0; n < 2; n++) begin
            src_cmd <= n ? '1 : '0;
            repeat (3) @(negedge clk);
            chk(cs[3], c == 2 || (n == 1 && c >= 4 && c <= 12));
            @(posedge clk);
         end
      end
      bus(1'b1, ATC_OFS_TSRC, {3'h0, ATC_TRG_GSW, 24'h0});
      bus(1'b1, ATC_OFS_CTRL3, 32'h00000040);
      n = 0;
      repeat (8) begin
         @(negedge clk);
         if (cs[3] === 1'b1) n++;
      end
      chk(n, 1);
      @(posedge clk);
      bus(1'b1, ATC_OFS_TSRC, {3'h0, ATC_TRG_SCAN, 24'h0});
      for (n = 1; n >= 0; n--) begin
         bus(1'b1, ATC_OFS_SCAN, {11'h0, ATC_TRG_INT0, 12'h0, 1'(n), 3'h0});
         @(negedge clk);
         chk(cs[3], n);
         @(posedge clk);
      end
      $display("test sources done");
      bus(1'b1, ATC_OFS_TSRC, 32'h00000000);
      bus(1'b1, ATC_OFS_SCAN, 32'h00000000);
      bus(1'b1, ATC_OFS_IMASK, 32'h00000002);
      bus(1'b1, ATC_OFS_CTRL3, 32'h00000200);
      @(negedge clk);
      chk(software_sample_hold, 1);
      @(posedge clk);
      bus(1'b1, ATC_OFS_CTRL3, 32'h00000000);
      @(negedge clk);
      chk(software_sample_hold, 0);
      @(posedge clk);
      d = {23'h0, 1'b1, 2'h0, 6'($urandom)};
      exp_q.push_back(d[5:0]);
      bus(1'b1, ATC_OFS_CTRL3, d);
      n = 0;
      repeat (4) begin
         @(negedge clk);
         if (rqs === 1'b1) n++;
         if (rqs === 1'b1 && exp_q.size() > 0) chk(rqi, exp_q.pop_front());
      end
      chk(n, 1);
      chk(irq, 1);
      @(posedge clk);
      rchk(ATC_OFS_CTRL3, {26'h0, d[5:0]});
      rchk(ATC_OFS_ISTAT, 32'h00000002);
      rchk(ATC_OFS_ISTAT, 32'h00000000);
      $display("test request done");
      slow <= 1'b1;
      bus(1'b1, ATC_OFS_TSRC, {3'h0, ATC_TRG_GLSW, 24'h0});
      bus(1'b1, ATC_OFS_IMASK, 32'h00000001);
      bus(1'b1, ATC_OFS_CTRL3, 32'h00000880);
      bus(1'b1, ATC_OFS_CTRL3, 32'h00001980);
      rchk(ATC_OFS_CTRL3, 32'h00001880);
      @(negedge clk);
      chk({rqs, cs}, 0);
      for (n = 0; irq !== 1'b1 && n < 40; n++) @(negedge clk);
      chk(irq, 1);
      @(posedge clk);
      rchk(ATC_OFS_CTRL3, 32'h00001C80);
      rchk(ATC_OFS_ISTAT, 32'h00000001);
      @(negedge clk);
      chk(irq, 0);
      @(posedge clk);
      bus(1'b1, ATC_OFS_CTRL3, 32'h00000080);
      @(negedge clk);
      chk(cs[3], 1);
      @(posedge clk);
      rchk(ATC_OFS_CTRL3, 32'h00000080);
      $display("test suspend done");
      test_done();
   end
endmodule
`default_nettype wire
